// ===== hdl/adc_pkg.sv
package adc_pkg;
    // --------------------------------------------------------------
    // Geometry and timing constants.
    // --------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int CLK_PS = 5000;
    localparam int ROW_CNT = 512;
    localparam int INIT_CYCLES = 8;
    localparam int CNT_W = 24;
    // Minimum and maximum strobe delays in picoseconds, then power-up wait, refresh interval and idle limit in us, ns and ms.
    localparam int ROW_ACTIVE_WIDTH_PS = 70000;
    localparam int COLUMN_ACTIVE_WIDTH_PS = 20000;
    localparam int ROW_PRECHARGE_TIME_PS = 50000;
    localparam int ROW_TO_COLUMN_DELAY_PS = 20000;
    localparam int ROW_TO_COLUMN_MAX_PS = 50000;
    localparam int COLUMN_ACCESS_TIME_PS = 20000;
    localparam int ROW_ACCESS_TIME_PS = 70000;
    localparam int COLUMN_TO_WRITE_DELAY_PS = 20000;
    localparam int WRITE_TO_ROW_LEAD_PS = 20000;
    localparam int PAGE_PRECHARGE_PS = 10000;
    localparam int READ_SETUP_TIME_PS = 0;
    localparam int CBR_SETUP_PS = 10000;
    localparam int POWERUP_WAIT_US = 200;
    localparam int REFRESH_INTERVAL_NS = 15600;
    localparam int IDLE_LIMIT_MS = 8;
    // Cycle counts: minimums round up, maximums round down.
    localparam int RAS_CYC = (ROW_ACTIVE_WIDTH_PS + CLK_PS - 1) / CLK_PS;
    localparam int CAS_CYC = (COLUMN_ACTIVE_WIDTH_PS + CLK_PS - 1) / CLK_PS;
    localparam int RP_CYC = (ROW_PRECHARGE_TIME_PS + CLK_PS - 1) / CLK_PS;
    localparam int RCD_CYC = (ROW_TO_COLUMN_DELAY_PS + CLK_PS - 1) / CLK_PS;
    localparam int RCDMAX_CYC = ROW_TO_COLUMN_MAX_PS / CLK_PS;
    localparam int CAC_CYC = (COLUMN_ACCESS_TIME_PS + CLK_PS - 1) / CLK_PS;
    localparam int RAC_CYC = (ROW_ACCESS_TIME_PS + CLK_PS - 1) / CLK_PS;
    localparam int CWD_CYC = (COLUMN_TO_WRITE_DELAY_PS + CLK_PS - 1) / CLK_PS;
    localparam int RWL_CYC = (WRITE_TO_ROW_LEAD_PS + CLK_PS - 1) / CLK_PS;
    localparam int CP_CYC = (PAGE_PRECHARGE_PS + CLK_PS - 1) / CLK_PS;
    localparam int RCS_CYC = (READ_SETUP_TIME_PS + CLK_PS - 1) / CLK_PS + 1;
    localparam int CSR_CYC = (CBR_SETUP_PS + CLK_PS - 1) / CLK_PS;
    localparam int POWERUP_CYC = POWERUP_WAIT_US * 1000000 / CLK_PS;
    localparam int REFRESH_CYC = REFRESH_INTERVAL_NS * 1000 / CLK_PS;
    localparam int IDLE_CYC = IDLE_LIMIT_MS * 1000000 / CLK_PS * 1000;

    // --------------------------------------------------------------
    // Command and pin carriers.
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        ADC_OP_READ  = 2'h0,
        ADC_OP_WRITE = 2'h1,
        ADC_OP_RMW   = 2'h2,
        ADC_OP_LATE  = 2'h3
    } adc_op_e;

    typedef struct packed {
        adc_op_e             op;
        logic [ADDR_W-1:0]   row;
        logic [ADDR_W-1:0]   col;
        logic                wdata;
        logic                page;
        logic                test;
    } adc_req_s;

    typedef struct packed {
        logic                ras_n;
        logic                cas_n;
        logic                we_n;
        logic                test_function_pin;
        logic [ADDR_W-1:0]   addr;
        logic                din;
    } adc_pins_s;
endpackage : adc_pkg

// ===== hdl/adc_delay.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter that times one strobe delay; done is high at zero.
module adc_delay #(
    parameter int W = 24
) (
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    input  wire logic         load_in,
    input  wire logic [W-1:0] value_in,
    output logic              done_out
);
    logic [W-1:0] cnt_ff;

    // --------------------------------------------------------------
    // Counter.
    // --------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cnt_ff <= '0;
        end else if (load_in) begin
            cnt_ff <= value_in;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - W'(1);
        end
    end

    // Done is a plain compare of the registered count.
    assign done_out = (cnt_ff == '0);
endmodule : adc_delay
`default_nettype wire

// ===== hdl/adc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl
    import adc_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC,
    parameter int REFRESH_CYCLES = REFRESH_CYC,
    parameter int IDLE_CYCLES    = IDLE_CYC,
    parameter int PAGE_MAX_CYC   = 20000,
    parameter bit USE_CBR        = 1'b1
) (
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    input  wire logic              req_valid_in,
    input  wire adc_pkg::adc_req_s req_in,
    output logic                   req_ready_out,
    output logic                   rdata_valid_out,
    output logic                   rdata_out,
    output logic                   rdata_z_out,
    output logic                   init_done_out,
    output adc_pkg::adc_pins_s     pins_out,
    input  wire logic              dq_in,
    input  wire logic              dq_oe_in
);
    import adc_pkg::*;

    // --------------------------------------------------------------
    // State.
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_POWERUP = 4'h0,
        ST_IDLE    = 4'h1,
        ST_RAS     = 4'h2,
        ST_CAS     = 4'h3,
        ST_WRITE   = 4'h4,
        ST_CASHI   = 4'h5,
        ST_PRECH   = 4'h6,
        ST_REF_CAS = 4'h7,
        ST_REF_RAS = 4'h8,
        ST_WAKE    = 4'h9
    } adc_state_e;

    typedef struct packed {
        adc_state_e         st;
        adc_pins_s          pins;
        adc_req_s           cur;
        logic [3:0]         wake_cnt;
        logic [ADDR_W-2:0]  ref_row;
        logic [CNT_W-1:0]   ref_tmr;
        logic [CNT_W-1:0]   idle_tmr;
        logic [CNT_W-1:0]   ras_tmr;
        logic               ref_due;
        logic               ready;
        logic               rvalid;
        logic               rdata;
        logic               rz;
        logic               init_done;
        logic               load;
        logic [CNT_W-1:0]   load_val;
    } adc_st_s;

    adc_st_s          s_ff;
    adc_st_s          nxt_s;
    logic             dly_done;
    logic [1:0]       dq_sync_ff;
    logic [1:0]       oe_sync_ff;

    // --------------------------------------------------------------
    // Pin input synchronisers.
    // --------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            dq_sync_ff <= 2'h0;
            oe_sync_ff <= 2'h0;
        end else begin
            dq_sync_ff <= {dq_sync_ff[0], dq_in};
            oe_sync_ff <= {oe_sync_ff[0], dq_oe_in};
        end
    end

    // Delay timer shared by every strobe phase.
    adc_delay #(.W(CNT_W)) u_delay (
        .clk_in   (clk_in),
        .srst_in  (srst_in),
        .load_in  (s_ff.load),
        .value_in (s_ff.load_val),
        .done_out (dly_done)
    );

    // --------------------------------------------------------------
    // Next-state logic.
    // --------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.load = 1'b0;
        nxt_s.load_val = '0;
        nxt_s.ready = 1'b0;
        nxt_s.rvalid = 1'b0;
        // Distributed refresh timer raises a request per interval.
        if (s_ff.ref_tmr == '0) begin
            nxt_s.ref_tmr = CNT_W'(REFRESH_CYCLES - 1);
            nxt_s.ref_due = 1'b1;
        end else begin
            nxt_s.ref_tmr = s_ff.ref_tmr - CNT_W'(1);
        end
        // Idle timer tracks strobe inactivity for wake-up.
        if (!s_ff.pins.ras_n) begin
            nxt_s.idle_tmr = '0;
        end else if (s_ff.idle_tmr != CNT_W'(IDLE_CYCLES)) begin
            nxt_s.idle_tmr = s_ff.idle_tmr + CNT_W'(1);
        end
        if (!s_ff.pins.ras_n) begin
            nxt_s.ras_tmr = s_ff.ras_tmr + CNT_W'(1);
        end else begin
            nxt_s.ras_tmr = '0;
        end
        case (s_ff.st)
            ST_POWERUP: begin
                if (dly_done && !s_ff.load) begin
                    nxt_s.st = ST_WAKE;
                    nxt_s.wake_cnt = 4'(INIT_CYCLES);
                end
            end
            ST_WAKE: begin
                // Row-only active cycles initialise the device.
                if (dly_done && !s_ff.load) begin
                    if (s_ff.wake_cnt == 4'h0) begin
                        nxt_s.st = ST_IDLE;
                        nxt_s.init_done = 1'b1;
                    end else begin
                        nxt_s.pins.ras_n = 1'b0;
                        nxt_s.pins.addr = ADDR_W'(s_ff.wake_cnt);
                        nxt_s.wake_cnt = s_ff.wake_cnt - 4'h1;
                        nxt_s.st = ST_REF_RAS;
                        nxt_s.load = 1'b1;
                        nxt_s.load_val = CNT_W'(RAS_CYC);
                    end
                end
            end
            ST_IDLE: begin
                // An offered ready is honoured first, so a request seen taken is never lost.
                if (req_valid_in && s_ff.ready) begin
                    nxt_s.cur = req_in;
                    nxt_s.pins.test_function_pin = req_in.test;
                    nxt_s.pins.addr = req_in.row;
                    if (req_in.test) begin
                        nxt_s.pins.addr[ADDR_W-1] = 1'b0;
                    end
                    nxt_s.pins.ras_n = 1'b0;
                    nxt_s.pins.we_n = (req_in.op != ADC_OP_WRITE);
                    nxt_s.st = ST_RAS;
                    nxt_s.load = 1'b1;
                    nxt_s.load_val = CNT_W'(RCD_CYC);
                end else if (s_ff.idle_tmr == CNT_W'(IDLE_CYCLES)) begin
                    nxt_s.st = ST_WAKE;
                    nxt_s.wake_cnt = 4'(INIT_CYCLES);
                end else if (s_ff.ref_due) begin
                    nxt_s.ref_due = (s_ff.ref_tmr == '0);
                    nxt_s.ref_row = s_ff.ref_row + 1'b1;
                    if (USE_CBR) begin
                        nxt_s.pins.cas_n = 1'b0;
                        nxt_s.st = ST_REF_CAS;
                        nxt_s.load = 1'b1;
                        nxt_s.load_val = CNT_W'(CSR_CYC);
                    end else begin
                        nxt_s.pins.ras_n = 1'b0;
                        nxt_s.pins.addr = ADDR_W'(s_ff.ref_row);
                        nxt_s.st = ST_REF_RAS;
                        nxt_s.load = 1'b1;
                        nxt_s.load_val = CNT_W'(RAS_CYC);
                    end
                end else begin
                    nxt_s.ready = 1'b1;
                end
            end
            ST_RAS: begin
                // Column phase after the row-to-column delay, or after RCS_CYC on a page hit.
                if (dly_done && !s_ff.load) begin
                    nxt_s.pins.addr = s_ff.cur.col;
                    if (s_ff.cur.test) begin
                        nxt_s.pins.addr[ADDR_W-1] = 1'b0;
                    end
                    nxt_s.pins.din = s_ff.cur.wdata;
                    nxt_s.pins.cas_n = 1'b0;
                    nxt_s.st = ST_CAS;
                    nxt_s.load = 1'b1;
                    nxt_s.load_val = CNT_W'((s_ff.cur.op == ADC_OP_WRITE) ? CAS_CYC
                                     : ((CAC_CYC > CWD_CYC) ? CAC_CYC : CWD_CYC) + 1);
                end
            end
            ST_CAS: begin
                // Reads also wait out the row access time plus the two-flop sync.
                if (dly_done && !s_ff.load && (s_ff.cur.op == ADC_OP_WRITE ||
                    s_ff.ras_tmr > CNT_W'(RAC_CYC + 1))) begin
                    if (s_ff.cur.op != ADC_OP_WRITE) begin
                        nxt_s.rdata = dq_sync_ff[1];
                        nxt_s.rz = !oe_sync_ff[1];
                        nxt_s.rvalid = (s_ff.cur.op == ADC_OP_READ) ||
                                       (s_ff.cur.op == ADC_OP_RMW);
                    end
                    if (s_ff.cur.op == ADC_OP_READ || s_ff.cur.op == ADC_OP_WRITE) begin
                        nxt_s.pins.cas_n = 1'b1;
                        nxt_s.st = ST_CASHI;
                        nxt_s.load = 1'b1;
                        nxt_s.load_val = CNT_W'(CP_CYC);
                    end else begin
                        nxt_s.pins.we_n = 1'b0;
                        nxt_s.st = ST_WRITE;
                        nxt_s.load = 1'b1;
                        nxt_s.load_val = CNT_W'(RWL_CYC);
                    end
                end
            end
            ST_WRITE: begin
                if (dly_done && !s_ff.load) begin
                    nxt_s.pins.cas_n = 1'b1;
                    nxt_s.st = ST_CASHI;
                    nxt_s.load = 1'b1;
                    nxt_s.load_val = CNT_W'(CP_CYC);
                end
            end
            ST_CASHI: begin
                nxt_s.pins.we_n = 1'b1;
                if (dly_done && !s_ff.load) begin
                    if (s_ff.cur.page && req_valid_in && req_in.page &&
                        req_in.row == s_ff.cur.row && !s_ff.ref_due &&
                        s_ff.ras_tmr < CNT_W'(PAGE_MAX_CYC)) begin
                        nxt_s.cur = req_in;
                        nxt_s.pins.we_n = (req_in.op != ADC_OP_WRITE);
                        nxt_s.st = ST_RAS;
                        nxt_s.ready = 1'b1;
                        nxt_s.load = 1'b1;
                        nxt_s.load_val = CNT_W'(RCS_CYC);
                    end else if (s_ff.ras_tmr >= CNT_W'(RAS_CYC)) begin
                        nxt_s.pins.ras_n = 1'b1;
                        nxt_s.pins.test_function_pin = 1'b0;
                        nxt_s.st = ST_PRECH;
                        nxt_s.load = 1'b1;
                        nxt_s.load_val = CNT_W'(RP_CYC);
                    end
                end
            end
            ST_PRECH: begin
                if (dly_done && !s_ff.load) begin
                    nxt_s.pins.cas_n = 1'b1;
                    nxt_s.st = (s_ff.init_done && s_ff.wake_cnt == 4'h0) ? ST_IDLE : ST_WAKE;
                end
            end
            ST_REF_CAS: begin
                // Column strobe leads row strobe for device counter refresh.
                if (dly_done && !s_ff.load) begin
                    nxt_s.pins.ras_n = 1'b0;
                    nxt_s.st = ST_REF_RAS;
                    nxt_s.load = 1'b1;
                    nxt_s.load_val = CNT_W'(RAS_CYC);
                end
            end
            ST_REF_RAS: begin
                if (dly_done && !s_ff.load) begin
                    nxt_s.pins.ras_n = 1'b1;
                    nxt_s.pins.cas_n = 1'b1;
                    nxt_s.st = ST_PRECH;
                    nxt_s.load = 1'b1;
                    nxt_s.load_val = CNT_W'(RP_CYC);
                end
            end
            default: begin
                nxt_s.st = ST_IDLE;
            end
        endcase
    end

    // --------------------------------------------------------------
    // State register.
    // --------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s_ff <= '0;
            s_ff.st <= ST_POWERUP;
            s_ff.pins.ras_n <= 1'b1;
            s_ff.pins.cas_n <= 1'b1;
            s_ff.pins.we_n <= 1'b1;
            s_ff.load <= 1'b1;
            s_ff.load_val <= CNT_W'(POWERUP_CYCLES);
            s_ff.ref_tmr <= CNT_W'(REFRESH_CYCLES - 1);
            s_ff.rz <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs come straight from the state register.
    assign req_ready_out   = s_ff.ready;
    assign rdata_valid_out = s_ff.rvalid;
    assign rdata_out       = s_ff.rdata;
    assign rdata_z_out     = s_ff.rz;
    assign init_done_out   = s_ff.init_done;
    assign pins_out        = s_ff.pins;
endmodule : adc_ctrl
`default_nettype wire

// ===== bench/adc_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_asserts
    import adc_pkg::*;
(
    input  wire logic               clk_in,
    input  wire logic               srst_in,
    input  wire logic               req_ready_out,
    input  wire logic               init_done_out,
    input  wire adc_pkg::adc_pins_s pins_out
);
    int ras_lo_ff;
    int ras_hi_ff;
    int cas_lo_ff;
    int cas_hi_ff;
    int we_lo_ff;
    // ----------------------------------------------------------------
    // Run lengths of each strobe level, in clock cycles.
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        ras_lo_ff <= pins_out.ras_n ? 0 : ras_lo_ff + 1;
        ras_hi_ff <= pins_out.ras_n ? ras_hi_ff + 1 : 0;
        cas_lo_ff <= pins_out.cas_n ? 0 : cas_lo_ff + 1;
        cas_hi_ff <= pins_out.cas_n ? cas_hi_ff + 1 : 0;
        we_lo_ff  <= pins_out.we_n ? 0 : we_lo_ff + 1;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    property p_ras_pre; $fell(pins_out.ras_n) |-> ras_hi_ff >= RP_CYC; endproperty
    a_ras_pre: assert property (p_ras_pre) else $error("row precharge too short");
    property p_ras_wid; $rose(pins_out.ras_n) |-> ras_lo_ff >= RAS_CYC; endproperty
    a_ras_wid: assert property (p_ras_wid) else $error("row strobe too short");
    property p_cas_wid; $rose(pins_out.cas_n) |-> cas_lo_ff >= CAS_CYC; endproperty
    a_cas_wid: assert property (p_cas_wid) else $error("column strobe too short");
    property p_rcd; $fell(pins_out.cas_n) && !pins_out.ras_n |-> ras_lo_ff >= RCD_CYC; endproperty
    a_rcd: assert property (p_rcd) else $error("column strobe too early");
    property p_cp; $fell(pins_out.cas_n) |-> cas_hi_ff >= CP_CYC; endproperty
    a_cp: assert property (p_cp) else $error("column precharge too short");
    property p_csr; $fell(pins_out.ras_n) && !pins_out.cas_n |-> cas_lo_ff >= CSR_CYC; endproperty
    a_csr: assert property (p_csr) else $error("refresh setup too short");
    property p_cwd; $fell(pins_out.we_n) && !pins_out.cas_n |-> cas_lo_ff >= CWD_CYC; endproperty
    a_cwd: assert property (p_cwd) else $error("write enable too early");
    property p_rwl; $rose(pins_out.cas_n) && !pins_out.we_n |-> we_lo_ff >= RWL_CYC;
    endproperty
    a_rwl: assert property (p_rwl) else $error("write lead too short");
    property p_end; $rose(pins_out.ras_n) |-> pins_out.cas_n; endproperty
    a_end: assert property (p_end) else $error("row released before column");
    property p_rhold; $rose(pins_out.cas_n) && $past(pins_out.we_n) |-> pins_out.we_n; endproperty
    a_rhold: assert property (p_rhold) else $error("read enable dropped");
    property p_a9; $fell(pins_out.cas_n) && pins_out.test_function_pin |-> !pins_out.addr[9];
    endproperty
    a_a9: assert property (p_a9) else $error("test column bit nine set");
    property p_init; req_ready_out |-> init_done_out; endproperty
    a_init: assert property (p_init) else $error("ready before wake-up");
    c_late: cover property ($fell(pins_out.we_n) && !pins_out.cas_n);
    c_cbr: cover property ($fell(pins_out.ras_n) && !pins_out.cas_n);
    c_test: cover property ($fell(pins_out.cas_n) && pins_out.test_function_pin);
endmodule : adc_ctrl_asserts
bind adc_ctrl adc_ctrl_asserts i_asserts (.clk_in(clk_in), .srst_in(srst_in),
    .req_ready_out(req_ready_out), .init_done_out(init_done_out), .pins_out(pins_out));
`default_nettype wire

// ===== bench/adc_dram_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_dram_model
    import adc_pkg::*;
#(
    parameter int ROW_ACCESS_NS = 70
) (
    input  wire adc_pkg::adc_pins_s pins_in,
    output logic                    dq_out,
    output logic                    dq_oe_out
);
    logic       mem [logic [19:0]];
    logic [9:0] row_q;
    logic [9:0] col_q;
    logic       cbr_q = 1'b0;
    realtime    ras_t = 0;
    int         n_ras = 0;
    int         n_refresh = 0;
    initial dq_oe_out = 1'b0;
    initial dq_out = 1'b1;
    function automatic logic rd(input logic [19:0] k);
        return mem.exists(k) ? mem[k] : 1'b0;
    endfunction : rd
    // Test mode writes the same bit into all four blocks.
    task automatic store(input logic d);
        if (pins_in.test_function_pin) begin
            for (int b = 0; b < 4; b++) mem[{b[1], row_q[8:0], b[0], col_q[8:0]}] = d;
        end else begin
            mem[{row_q, col_q}] = d;
        end
    endtask : store
    // A row strobe fall with the column strobe low refreshes from the inner counter.
    always @(negedge pins_in.ras_n) begin
        n_ras++;
        ras_t = $realtime;
        if (!pins_in.cas_n) begin
            cbr_q = 1'b1;
            n_refresh++;
        end else begin
            row_q = pins_in.addr;
        end
    end
    always @(posedge pins_in.ras_n) cbr_q = 1'b0;
    // Column fall latches the column; reads show junk until the access time.
    always @(negedge pins_in.cas_n) begin
        logic    x [4];
        logic    v;
        logic    same;
        realtime w;
        if (!pins_in.ras_n && !cbr_q) begin
            col_q = pins_in.addr;
            if (!pins_in.we_n) begin
                store(pins_in.din);
            end else begin
                for (int b = 0; b < 4; b++) x[b] = rd({b[1], row_q[8:0], b[0], col_q[8:0]});
                v = pins_in.test_function_pin ? x[0] : rd({row_q, col_q});
                same = !pins_in.test_function_pin || (x[0] == x[1] && x[1] == x[2] && x[2] == x[3]);
                dq_oe_out = 1'b1;
                dq_out = ~v;
                w = ras_t + ROW_ACCESS_NS - $realtime;
                if (w < COLUMN_ACCESS_TIME_PS / 1000.0) w = COLUMN_ACCESS_TIME_PS / 1000.0;
                #(w);
                if (!pins_in.cas_n) begin
                    dq_out = v;
                    dq_oe_out = same;
                end
            end
        end
    end
    // Output floats once the column strobe goes inactive.
    always @(posedge pins_in.cas_n) begin
        dq_oe_out = 1'b0;
        dq_out = ~dq_out;
    end
    always @(negedge pins_in.we_n) begin
        if (!pins_in.ras_n && !pins_in.cas_n && !cbr_q) store(pins_in.din);
    end
endmodule : adc_dram_model
`default_nettype wire

// ===== bench/async_dram_cycle_protocol_test.sv
`timescale 1ns/1ps
`default_nettype none
module async_dram_cycle_protocol_test;
    import adc_pkg::*;
    localparam int PWR_CYC = 50;
    logic      clk_in;
    logic      srst_in;
    logic      req_valid_in;
    adc_req_s  req_in;
    logic      req_ready_out;
    logic      rdata_valid_out;
    logic      rdata_out;
    logic      rdata_z_out;
    logic      init_done_out;
    adc_pins_s pins_out;
    logic      dq;
    logic      dq_oe;
    int        n_fail = 0;
    int        checks = 0;
    adc_ctrl #(.POWERUP_CYCLES(PWR_CYC), .REFRESH_CYCLES(200), .IDLE_CYCLES(5000),
        .PAGE_MAX_CYC(20000), .USE_CBR(1'b1)) i_dut (.clk_in(clk_in), .srst_in(srst_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
        .rdata_valid_out(rdata_valid_out), .rdata_out(rdata_out), .rdata_z_out(rdata_z_out),
        .init_done_out(init_done_out), .pins_out(pins_out), .dq_in(dq), .dq_oe_in(dq_oe));
    adc_dram_model i_mem (.pins_in(pins_out), .dq_out(dq), .dq_oe_out(dq_oe));
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
            n_fail++;
        end
    endtask : chk
    // One request: offered after an edge, held until the ready edge, reads judged.
    task automatic xfer(input adc_op_e op, input logic [9:0] row, input logic [9:0] col,
                        input logic wd, input logic pg, input logic tm, input logic ez,
                        input logic ed);
        int i;
        @(posedge clk_in);
        #1 req_in = '{op, row, col, wd, pg, tm};
        req_valid_in = 1'b1;
        for (i = 0; i < 400; i++) begin
            @(posedge clk_in);
            if (req_ready_out === 1'b1) break;
        end
        chk("request taken", 1'b1, i < 400);
        #1 req_valid_in = 1'b0;
        if (op == ADC_OP_READ || op == ADC_OP_RMW) begin
            for (i = 0; i < 200 && rdata_valid_out !== 1'b1; i++) @(posedge clk_in);
            #1 chk("read answered", 1'b1, i < 200);
            chk("read float", ez, rdata_z_out);
            if (!ez) chk("read data", ed, rdata_out);
        end
    endtask : xfer
    task automatic t_init();
        int c;
        int n0;
        n0 = i_mem.n_ras;
        for (c = 0; c < 2000 && init_done_out !== 1'b1; c++) @(posedge clk_in);
        #1 chk("wake-up done", 1'b1, init_done_out);
        chk("power-up wait", 1'b1, c >= PWR_CYC);
        chk("wake-up row cycles", 1'b1, i_mem.n_ras - n0 >= INIT_CYCLES);
    endtask : t_init
    task automatic t_rw();
        logic [9:0] r;
        for (int k = 0; k < 2; k++) begin
            r = k ? 10'h3ff : 10'h000;
            xfer(ADC_OP_WRITE, r, ~r, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
            xfer(ADC_OP_READ, r, ~r, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
            xfer(ADC_OP_LATE, r, ~r, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            xfer(ADC_OP_READ, r, ~r, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            xfer(ADC_OP_RMW, r, ~r, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
            xfer(ADC_OP_READ, r, ~r, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        end
    endtask : t_rw
    task automatic t_page();
        int nr;
        int nf;
        nf = i_mem.n_refresh;
        // Start right after a refresh, so none can close the page mid-burst.
        while (i_mem.n_refresh == nf) @(posedge clk_in);
        nr = i_mem.n_ras;
        nf = i_mem.n_refresh;
        xfer(ADC_OP_WRITE, 10'h155, 10'h010, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        xfer(ADC_OP_LATE, 10'h155, 10'h011, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        xfer(ADC_OP_RMW, 10'h155, 10'h010, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        chk("one row open", 1'b1, (i_mem.n_ras - nr) - (i_mem.n_refresh - nf) == 1);
        xfer(ADC_OP_READ, 10'h155, 10'h011, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        xfer(ADC_OP_READ, 10'h155, 10'h010, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    endtask : t_page
    task automatic t_test();
        for (int b = 0; b < 4; b++) begin
            xfer(ADC_OP_WRITE, {b[1], 9'h0a0}, {b[0], 9'h0c3}, b != 3, 1'b0, 1'b0, 1'b0, 1'b0);
        end
        xfer(ADC_OP_READ, 10'h0a0, 10'h0c3, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        xfer(ADC_OP_WRITE, 10'h2a0, 10'h2c3, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        xfer(ADC_OP_READ, 10'h0a0, 10'h0c3, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        xfer(ADC_OP_READ, 10'h2a0, 10'h2c3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    endtask : t_test
    task automatic t_refresh();
        int n0;
        int d;
        n0 = i_mem.n_refresh;
        repeat (2000) @(posedge clk_in);
        #1 d = i_mem.n_refresh - n0;
        chk("refresh rate", 1'b1, d >= 9 && d <= 11);
    endtask : t_refresh
    task automatic t_reset();
        @(posedge clk_in);
        #1 srst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 srst_in = 1'b0;
        chk("wake-up cleared", 1'b0, init_done_out);
        t_init();
        xfer(ADC_OP_READ, 10'h155, 10'h011, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    endtask : t_reset
    // Watchdog cuts a hang short.
    initial begin
        #100000;
        n_fail++;
        test_done();
    end
    // Main sequence.
    initial begin
        srst_in = 1'b1;
        req_valid_in = 1'b0;
        req_in = '0;
        repeat (2) @(posedge clk_in);
        #1 srst_in = 1'b0;
        t_init();
        t_rw();
        t_page();
        t_test();
        t_refresh();
        t_reset();
        test_done();
    end
endmodule : async_dram_cycle_protocol_test
`default_nettype wire
